// ---- src/adh_pkg.sv ----
// Operation
// - idle opcode enters idle, interrupts, skips spin-up when already spinning
// - nonzero count except FE arms standby timer, zero disables
// - counts 1-240 times 5s, 241-251 less 240 times 30min
// - FC 21min, FD 8h, FE reserved, FF 21m15s
// - idle immediate enters idle, interrupts at once
// - geometry setup stores values unchecked, then interrupts
// - nop always answers command aborted
// - buffer read sets DRQ, host reads 512 bytes
// - buffer write and read share one region
// - DMA read one interrupt, stops before bad sector
// - up to 32 queued commands, any completion order
// - non-queued or duplicate tag during queue errors
// - long read sends sector plus ECC bytes, unchecked
// - multiple read interrupts per block, remainder last
// - multiple read without block mode is aborted
// - block error posted at failing sector, stops at block end, correctable continues
// - sector read 1-256 sectors, registers hold last
// - sector read always sets DRQ before data
// - verify never DRQ, leaves unverified count on error
// - recalibrate seeks cylinder zero, error if unreachable
// - identify word 128 reports security status bits
package adh_pkg;
   localparam logic [7:0] OP_NOP = 8'h00;
   localparam logic [7:0] OP_RECAL = 8'h10;
   localparam logic [7:0] OP_RD_SEC = 8'h20;
   localparam logic [7:0] OP_RD_LONG = 8'h22;
   localparam logic [7:0] OP_RD_SEC_X = 8'h24;
   localparam logic [7:0] OP_RD_DMA_X = 8'h25;
   localparam logic [7:0] OP_RD_MUL_X = 8'h29;
   localparam logic [7:0] OP_VFY = 8'h40;
   localparam logic [7:0] OP_VFY_X = 8'h41;
   localparam logic [7:0] OP_QREAD = 8'h60;
   localparam logic [7:0] OP_GEOM = 8'h91;
   localparam logic [7:0] OP_RD_MUL = 8'hC4;
   localparam logic [7:0] OP_RD_DMA = 8'hC8;
   localparam logic [7:0] OP_IDLE_NOW = 8'hE1;
   localparam logic [7:0] OP_IDLE = 8'hE3;
   localparam logic [7:0] OP_RD_BUF = 8'hE4;
   localparam logic [7:0] OP_WR_BUF = 8'hE8;
   localparam int CLK_HZ = 10_000_000;
   localparam int T_UNIT_S = 5;
   localparam int T_LONG_MIN = 30;
   localparam int T_FC_MIN = 21;
   localparam int T_FD_HOURS = 8;
   localparam int T_FF_S = 21 * 60 + 15;
   localparam logic [7:0] T_LIN_MAX = 8'hF0;
   localparam logic [7:0] T_HALF_MAX = 8'hFB;
   // timer counts seconds; a cycle prescaler makes the seconds
   localparam int SEC_CYCLES = CLK_HZ;
   localparam int BUF_WORDS = 256;
   localparam int QDEPTH = 32;
   localparam int ECC_BYTES = 4;
   // error register bits
   localparam int ERR_ABRT = 2;
   localparam int ERR_TK0NF = 1;
   localparam int ERR_UNC = 6;
   localparam int ERR_IDNF = 4;
   // security word bit positions
   localparam int SEC_SUPP = 0;
   localparam int SEC_EN = 1;
   localparam int SEC_LOCK = 2;
   localparam int SEC_FRZ = 3;
   localparam int SEC_EXP = 4;
   localparam int SEC_ENH = 5;
   localparam int SEC_LVL = 8;
   localparam logic [15:0] SEC_RESET = 16'h0021;

   typedef struct packed {
      logic [7:0] cmd;
      logic [15:0] count;
      logic [47:0] lba;
      logic [3:0] head;
      logic [4:0] tag;
   } adh_cmd_s;

   typedef struct packed {
      logic bsy;
      logic drq;
      logic err;
      logic [7:0] error;
   } adh_stat_s;

   typedef enum logic [1:0] {PM_ACTIVE, PM_IDLE, PM_STANDBY} adh_pm_e;
endpackage : adh_pkg

// ---- src/adh_cmd.sv ----
`timescale 1ns/10ps
module adh_cmd #(
   parameter int SEC_CYC = adh_pkg::SEC_CYCLES,
   parameter int MEDIA_LAT = 4
) (
   input wire logic clk,
   input wire logic rstn,
   // command block
   input wire logic cmd_valid,
   input wire adh_pkg::adh_cmd_s cmd_in,
   output adh_pkg::adh_stat_s stat,
   output logic irq,
   output logic [15:0] cmd_count,
   output logic [47:0] cmd_lba,
   // pio / dma data toward host, one byte per beat
   output logic [7:0] rd_data,
   output logic rd_valid,
   input wire logic rd_ready,
   // buffer write from host
   input wire logic wr_valid,
   input wire logic [7:0] wr_data,
   // media side, same clock
   output logic media_req,
   output logic [47:0] media_lba,
   input wire logic media_ack,
   input wire logic media_err,
   input wire logic media_corr,
   input wire logic [7:0] media_data,
   input wire logic seek_ok,
   input wire logic spinning,
   output logic spin_up,
   // configuration and status
   input wire logic [7:0] mult_block,
   input wire logic mult_enable,
   input wire logic q_done,
   input wire logic [4:0] q_done_tag,
   output logic q_err,
   output logic [31:0] q_busy,
   output adh_pkg::adh_pm_e pm_mode,
   output logic [7:0] geom_spt,
   output logic [3:0] geom_heads,
   input wire logic [15:0] sec_state,
   output logic [15:0] sec_word
);
   typedef enum {S_IDLE, S_SEEK, S_FETCH, S_XFER, S_DONE} adh_st_e;
   adh_st_e st_reg;
   adh_pkg::adh_cmd_s cur_reg;
   // lower half holds the host's 512 bytes; staged media byte sits at the start of the upper half
   logic [7:0] buf_mem [adh_pkg::BUF_WORDS * 4];
   logic [8:0] bptr_reg;
   logic [9:0] xfer_left_reg;
   logic [15:0] sec_left_reg;
   logic [15:0] blk_left_reg;
   logic blk_err_reg;
   logic [31:0] tmr_sec_reg;
   logic [31:0] presc_reg;
   logic tmr_on_reg;

   // ------------------------------------------------------------
   // standby timeout decode, in seconds
   // ------------------------------------------------------------
   function automatic logic [31:0] tmo_secs(input logic [7:0] sc);
      logic [31:0] r;
      r = 32'h0;
      if (sc != 8'h00 && sc <= adh_pkg::T_LIN_MAX) begin
         r = 32'(sc) * adh_pkg::T_UNIT_S;
      end else if (sc > adh_pkg::T_LIN_MAX && sc <= adh_pkg::T_HALF_MAX) begin
         r = 32'(sc - adh_pkg::T_LIN_MAX) * adh_pkg::T_LONG_MIN * 60;
      end else begin
         // special codes, reserved code leaves timer off
         case (sc)
            8'hFC: r = adh_pkg::T_FC_MIN * 60;
            8'hFD: r = adh_pkg::T_FD_HOURS * 3600;
            8'hFF: r = adh_pkg::T_FF_S;
            default: r = 32'h0;
         endcase
      end
      return r;
   endfunction : tmo_secs

   function automatic logic is_read(input logic [7:0] op);
      return op == adh_pkg::OP_RD_SEC || op == adh_pkg::OP_RD_SEC_X || op == adh_pkg::OP_RD_DMA
         || op == adh_pkg::OP_RD_DMA_X || op == adh_pkg::OP_RD_MUL || op == adh_pkg::OP_RD_MUL_X
         || op == adh_pkg::OP_RD_LONG || op == adh_pkg::OP_VFY || op == adh_pkg::OP_VFY_X;
   endfunction : is_read

   wire logic cur_dma = cur_reg.cmd == adh_pkg::OP_RD_DMA || cur_reg.cmd == adh_pkg::OP_RD_DMA_X;
   wire logic cur_mul = cur_reg.cmd == adh_pkg::OP_RD_MUL || cur_reg.cmd == adh_pkg::OP_RD_MUL_X;
   wire logic cur_vfy = cur_reg.cmd == adh_pkg::OP_VFY || cur_reg.cmd == adh_pkg::OP_VFY_X;
   wire logic cur_long = cur_reg.cmd == adh_pkg::OP_RD_LONG;
   wire logic cur_buf = cur_reg.cmd == adh_pkg::OP_RD_BUF;
   wire logic take = cmd_valid && st_reg == S_IDLE;
   wire logic beat = rd_valid && rd_ready;
   wire logic [15:0] blk = mult_block == 8'h00 ? 16'h1 : {8'h00, mult_block};

   // ------------------------------------------------------------
   // security identify word
   // ------------------------------------------------------------
   // security word
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sec_word <= adh_pkg::SEC_RESET;
      end else begin
         sec_word <= {7'h00, sec_state[adh_pkg::SEC_LVL], 2'b00, sec_state[adh_pkg::SEC_ENH:adh_pkg::SEC_SUPP]};
      end
   end

   // ------------------------------------------------------------
   // queued tags
   // ------------------------------------------------------------
   // tag tracking, completion in any order
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q_busy <= 32'h0;
         q_err <= 1'b0;
      end else begin
         q_err <= 1'b0;
         if (q_done) begin
            q_busy[q_done_tag] <= 1'b0;
         end
         if (take && cur_st_q(cmd_in.cmd)) begin
            if (q_busy[cmd_in.tag] && !(q_done && q_done_tag == cmd_in.tag)) begin
               q_err <= 1'b1;
            end else begin
               q_busy[cmd_in.tag] <= 1'b1;
            end
         end else if (take && q_busy != 32'h0) begin
            q_err <= 1'b1;
         end
      end
   end

   function automatic logic cur_st_q(input logic [7:0] op);
      return op == adh_pkg::OP_QREAD;
   endfunction : cur_st_q

   // ------------------------------------------------------------
   // power mode and standby timer
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pm_mode <= adh_pkg::PM_ACTIVE;
         tmr_on_reg <= 1'b0;
         tmr_sec_reg <= 32'h0;
         presc_reg <= 32'h0;
         spin_up <= 1'b0;
      end else begin
         spin_up <= 1'b0;
         if (take && (cmd_in.cmd == adh_pkg::OP_IDLE || cmd_in.cmd == adh_pkg::OP_IDLE_NOW)) begin
            // idle entry, spin-up only if stopped
            pm_mode <= adh_pkg::PM_IDLE;
            spin_up <= !spinning;
            if (cmd_in.cmd == adh_pkg::OP_IDLE) begin
               tmr_sec_reg <= tmo_secs(cmd_in.count[7:0]);
               tmr_on_reg <= tmo_secs(cmd_in.count[7:0]) != 32'h0;
               presc_reg <= 32'h0;
            end
         end else if (tmr_on_reg && pm_mode == adh_pkg::PM_IDLE) begin
            if (presc_reg == 32'(SEC_CYC - 1)) begin
               presc_reg <= 32'h0;
               if (tmr_sec_reg <= 32'h1) begin
                  pm_mode <= adh_pkg::PM_STANDBY;
               end
               tmr_sec_reg <= tmr_sec_reg - 32'h1;
            end else begin
               presc_reg <= presc_reg + 32'h1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // sector buffer, two halves: media staging and host buffer
   // ------------------------------------------------------------
   // write and read share bptr region
   always_ff @(posedge clk) begin
      if (wr_valid && st_reg == S_IDLE) begin
         buf_mem[{1'b0, bptr_reg}] <= wr_data;
      end
      if (st_reg == S_FETCH && media_ack) begin
         buf_mem[10'h200] <= media_data;
      end
   end

   // ------------------------------------------------------------
   // command sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= S_IDLE;
         cur_reg <= '0;
         stat <= '0;
         irq <= 1'b0;
         bptr_reg <= 9'h0;
         xfer_left_reg <= 10'h0;
         sec_left_reg <= 16'h0;
         blk_left_reg <= 16'h0;
         blk_err_reg <= 1'b0;
         geom_spt <= 8'h00;
         geom_heads <= 4'h0;
         cmd_count <= 16'h0;
         cmd_lba <= 48'h0;
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
         media_req <= 1'b0;
         media_lba <= 48'h0;
      end else begin
         irq <= 1'b0;
         if (wr_valid && st_reg == S_IDLE) begin
            bptr_reg <= bptr_reg + 9'h1;
         end
         case (st_reg)
            S_IDLE: begin
               if (take) begin
                  cur_reg <= cmd_in;
                  cmd_count <= cmd_in.count;
                  cmd_lba <= cmd_in.lba;
                  stat <= '{bsy: 1'b1, drq: 1'b0, err: 1'b0, error: 8'h00};
                  // zero count is 256 except for OP_RD_DMA_X and OP_RD_MUL_X
                  sec_left_reg <= (cmd_in.count == 16'h0 && cmd_in.cmd != adh_pkg::OP_RD_DMA_X
                     && cmd_in.cmd != adh_pkg::OP_RD_MUL_X) ? 16'd256 : cmd_in.count;
                  st_reg <= S_DONE;
                  if (cmd_in.cmd == adh_pkg::OP_QREAD) begin
                     stat.bsy <= 1'b0;
                     st_reg <= S_IDLE;
                  end else if (q_busy != 32'h0 || cmd_in.cmd == adh_pkg::OP_NOP
                     || ((cmd_in.cmd == adh_pkg::OP_RD_MUL || cmd_in.cmd == adh_pkg::OP_RD_MUL_X)
                     && (!mult_enable || mult_block == 8'h00))) begin
                     stat.err <= 1'b1;
                     stat.error[adh_pkg::ERR_ABRT] <= 1'b1;
                  end else if (cmd_in.cmd == adh_pkg::OP_GEOM) begin
                     geom_spt <= cmd_in.count[7:0];
                     geom_heads <= cmd_in.head;
                  end else if (cmd_in.cmd == adh_pkg::OP_RECAL) begin
                     media_req <= 1'b1;
                     media_lba <= 48'h0;
                     st_reg <= S_SEEK;
                  end else if (cmd_in.cmd == adh_pkg::OP_RD_BUF) begin
                     bptr_reg <= 9'h0;
                     xfer_left_reg <= 10'd512;
                     st_reg <= S_XFER;
                  end else if (cmd_in.cmd == adh_pkg::OP_WR_BUF) begin
                     bptr_reg <= 9'h0;
                  end else if (is_read(cmd_in.cmd)) begin
                     blk_left_reg <= 16'h0;
                     media_req <= 1'b1;
                     media_lba <= cmd_in.lba;
                     st_reg <= S_FETCH;
                  end
               end
            end
            S_SEEK: begin
               if (media_ack) begin
                  media_req <= 1'b0;
                  stat.err <= !seek_ok;
                  stat.error[adh_pkg::ERR_TK0NF] <= !seek_ok;
                  if (seek_ok) begin
                     cmd_lba <= 48'h0;
                  end
                  st_reg <= S_DONE;
               end
            end
            S_FETCH: begin
               if (media_ack) begin
                  media_req <= 1'b0;
                  cmd_lba <= media_lba;
                  if (media_err && !(cur_mul && media_corr)) begin
                     stat.err <= 1'b1;
                     stat.error[adh_pkg::ERR_UNC] <= 1'b1;
                  end
                  if (media_err && (cur_dma || cur_vfy)) begin
                     cmd_count <= sec_left_reg;
                     st_reg <= S_DONE;
                  end else if (cur_vfy) begin
                     sec_left_reg <= sec_left_reg - 16'h1;
                     media_lba <= media_lba + 48'h1;
                     media_req <= sec_left_reg != 16'h1;
                     if (sec_left_reg == 16'h1) begin
                        st_reg <= S_DONE;
                     end
                  end else begin
                     // long read adds ECC bytes; DRQ always
                     xfer_left_reg <= cur_long ? 10'(1 + adh_pkg::ECC_BYTES) : 10'd1;
                     bptr_reg <= 9'h0;
                     blk_err_reg <= blk_err_reg | (media_err && !media_corr);
                     stat.drq <= 1'b1;
                     stat.bsy <= 1'b0;
                     // interrupt at block start, DMA once only
                     if (!cur_dma && (!cur_mul || blk_left_reg == 16'h0)) begin
                        irq <= 1'b1;
                     end
                     if (cur_mul && blk_left_reg == 16'h0) begin
                        blk_left_reg <= (sec_left_reg < blk ? sec_left_reg : blk) - 16'h1;
                     end else if (cur_mul) begin
                        blk_left_reg <= blk_left_reg - 16'h1;
                     end
                     st_reg <= S_XFER;
                  end
               end
            end
            S_XFER: begin
               stat.drq <= 1'b1;
               stat.bsy <= 1'b0;
               if (cur_buf && xfer_left_reg == 10'd512) begin
                  irq <= !rd_valid;
               end
               if (!rd_valid || beat) begin
                  if (xfer_left_reg != 10'h0) begin
                     rd_valid <= 1'b1;
                     rd_data <= cur_long && bptr_reg != 9'h0 ? 8'h00
                        : buf_mem[cur_buf ? {1'b0, bptr_reg} : 10'h200];
                     bptr_reg <= bptr_reg + 9'h1;
                     xfer_left_reg <= xfer_left_reg - 10'h1;
                  end else begin
                     rd_valid <= 1'b0;
                     stat.drq <= 1'b0;
                     if (cur_buf || cur_long || sec_left_reg == 16'h1
                        || (stat.err && !cur_mul) || (cur_mul && blk_left_reg == 16'h0 && blk_err_reg)) begin
                        st_reg <= S_DONE;
                     end else begin
                        stat.bsy <= 1'b1;
                        sec_left_reg <= sec_left_reg - 16'h1;
                        media_lba <= media_lba + 48'h1;
                        media_req <= 1'b1;
                        st_reg <= S_FETCH;
                     end
                  end
               end
            end
            S_DONE: begin
               // completion: clear busy; interrupt unless a pio or buffer read already did
               stat.bsy <= 1'b0;
               stat.drq <= 1'b0;
               // pio reads already interrupted at each drq block
               if (stat.error[adh_pkg::ERR_ABRT]
                  || !(cur_buf || (is_read(cur_reg.cmd) && !cur_dma && !cur_vfy))) begin
                  irq <= 1'b1;
               end
               st_reg <= S_IDLE;
            end
            default: st_reg <= S_IDLE;
         endcase
      end
   end
endmodule : adh_cmd

// ---- bench/adh_media_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// media side partner: one byte per sector
// ----------------------------------------
module adh_media_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic media_req,
   input wire logic [47:0] media_lba,
   input wire logic slow,
   input wire logic bad_en,
   input wire logic [47:0] bad_lba,
   output logic media_ack,
   output logic media_err,
   output logic [7:0] media_data
);
   logic [3:0] cnt_reg;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= 4'h0;
         media_ack <= 1'b0;
         media_err <= 1'b0;
         media_data <= 8'h00;
      end else begin
         media_ack <= 1'b0;
         // data is not held between acks, so a stale byte never looks valid
         media_data <= ~media_data;
         if (cnt_reg == 4'h1) begin
            media_ack <= 1'b1;
            media_data <= media_lba[7:0] ^ 8'h5A;
            media_err <= bad_en && media_lba == bad_lba;
         end
         if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
         end else if (media_req && !media_ack) begin
            cnt_reg <= slow ? 4'h6 : 4'h2;
         end
      end
   end
endmodule : adh_media_model

// ---- bench/adh_cmd_sva.sv ----
`timescale 1ns/10ps
module adh_chk (
   input wire logic clk,
   input wire logic rstn,
   input wire logic cmd_valid,
   input wire adh_pkg::adh_cmd_s cmd_in,
   input wire adh_pkg::adh_stat_s stat,
   input wire logic irq,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid,
   input wire logic rd_ready,
   input wire logic spinning,
   input wire logic spin_up,
   input wire logic q_err,
   input wire logic [31:0] q_busy,
   input wire adh_pkg::adh_pm_e pm_mode,
   input wire logic [7:0] geom_spt,
   input wire logic [3:0] geom_heads,
   input wire logic [15:0] sec_state,
   input wire logic [15:0] sec_word
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   logic take;
   logic [7:0] op;
   assign take = cmd_valid && !stat.bsy && !rd_valid;
   assign op = cmd_in.cmd;

   a_irq_one_pulse: assert property (irq |=> !irq)
      else $error("irq longer than one cycle");
   a_idle_now_walk: assert property (take && op == adh_pkg::OP_IDLE_NOW |=>
      stat.bsy && pm_mode == adh_pkg::PM_IDLE ##1 !stat.bsy && irq) else $error("idle immediate walk");
   a_nop_aborts: assert property (take && op == adh_pkg::OP_NOP |->
      ##2 irq && stat.err && stat.error[adh_pkg::ERR_ABRT]) else $error("nop not aborted");
   a_geom_stored: assert property (take && op == adh_pkg::OP_GEOM |-> ##2 irq &&
      geom_spt == $past(cmd_in.count[7:0], 2) && geom_heads == $past(cmd_in.head, 2)) else $error("geometry");
   a_sec_word_map: assert property ($past(rstn) |->
      sec_word == ($past(sec_state) & 16'h013F)) else $error("security word");
   a_verify_no_drq: assert property (take && (op == adh_pkg::OP_VFY || op == adh_pkg::OP_VFY_X) |=>
      (!rd_valid && !stat.drq) throughout (##[0:300] irq)) else $error("verify sent data");
   a_byte_held: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
      else $error("read byte dropped");
   a_dup_tag_err: assert property (take && op == adh_pkg::OP_QREAD && q_busy[cmd_in.tag] |->
      ##[1:3] q_err) else $error("duplicate tag accepted");
   a_spin_skipped: assert property (take && op == adh_pkg::OP_IDLE && spinning |->
      ##1 !spin_up ##1 !spin_up) else $error("spin-up while spinning");

   c_mult: cover property (take && op == adh_pkg::OP_RD_MUL);
   c_qerr: cover property (q_err);
   c_standby: cover property (pm_mode == adh_pkg::PM_STANDBY);
endmodule : adh_chk

bind adh_cmd adh_chk adh_chk_i (.clk, .rstn, .cmd_valid, .cmd_in, .stat, .irq, .rd_data, .rd_valid, .rd_ready,
   .spinning, .spin_up, .q_err, .q_busy, .pm_mode, .geom_spt, .geom_heads, .sec_state, .sec_word);

// ---- bench/tb.sv ----
`timescale 1ns/10ps
module tb;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic cmd_valid = 1'b0;
   logic rd_ready = 1'b1;
   logic wr_valid = 1'b0;
   logic media_corr = 1'b0;
   logic seek_ok = 1'b1;
   logic spinning = 1'b0;
   logic mult_enable = 1'b1;
   logic q_done = 1'b0;
   logic slow = 1'b0;
   logic bad_en = 1'b0;
   logic quiet = 1'b0;
   logic q_seen = 1'b0;
   logic [7:0] wr_data = 8'h00;
   logic [7:0] mult_block = 8'h02;
   logic [4:0] q_done_tag = 5'h00;
   logic [15:0] sec_state = 16'h0000;
   logic [47:0] bad_lba = 48'h0;
   adh_pkg::adh_cmd_s cmd_in = '0;
   adh_pkg::adh_stat_s stat;
   adh_pkg::adh_pm_e pm_mode;
   logic irq, rd_valid, media_req, media_ack, media_err, spin_up, q_err;
   logic [7:0] rd_data, media_data, geom_spt;
   logic [3:0] geom_heads;
   logic [15:0] cmd_count, sec_word;
   logic [31:0] q_busy;
   logic [47:0] cmd_lba, media_lba;
   int n_errors = 0;
   int total_checks = 0;
   logic [2:0] exp_irq[$];
   logic [7:0] exp_byte[$];
   // one timer second is two cycles here
   localparam int SC = 2;
   logic [7:0] codes[7] = '{8'h01, 8'hF0, 8'hF1, 8'hFC, 8'hFD, 8'hFF, 8'h00};
   int secs[7] = '{5, 1200, 1800, 1260, 28800, 1275, 0};

   adh_cmd #(.SEC_CYC(SC)) adh_cmd_i (.clk, .rstn, .cmd_valid, .cmd_in, .stat, .irq, .cmd_count, .cmd_lba,
      .rd_data, .rd_valid, .rd_ready, .wr_valid, .wr_data, .media_req, .media_lba, .media_ack, .media_err,
      .media_corr, .media_data, .seek_ok, .spinning, .spin_up, .mult_block, .mult_enable, .q_done,
      .q_done_tag, .q_err, .q_busy, .pm_mode, .geom_spt, .geom_heads, .sec_state, .sec_word);
   adh_media_model adh_media_model_i (.clk, .rstn, .media_req, .media_lba, .slow, .bad_en, .bad_lba,
      .media_ack, .media_err, .media_data);

   initial begin
      forever #50 clk = ~clk;
   end

   task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wrap_up;
      $display("errors %0d checks %0d", n_errors, total_checks);
      if (n_errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : wrap_up

   task automatic issue(input logic [7:0] op, input logic [15:0] cnt, input logic [47:0] lba, input logic [4:0] tg);
      @(posedge clk);
      cmd_in <= '{cmd: op, count: cnt, lba: lba, head: tg[3:0], tag: tg};
      cmd_valid <= 1'b1;
      @(posedge clk);
      cmd_valid <= 1'b0;
   endtask : issue

   task automatic settle;
      int i;
      for (i = 0; i < 5000 && (exp_irq.size() != 0 || exp_byte.size() != 0 || stat.bsy !== 1'b0); i++)
         @(posedge clk);
      if (i == 5000) begin
         chk(1, 0, "completion");
         wrap_up();
      end
      repeat (2) @(posedge clk);
   endtask : settle

   task automatic expect_rd(input logic [47:0] lba, input int n);
      for (int i = 0; i < n; i++)
         exp_byte.push_back(8'(lba + i) ^ 8'h5A);
   endtask : expect_rd

   // ----------------------------------------
   // scoreboard
   // ----------------------------------------
   always @(posedge clk) begin
      rd_ready <= ($urandom % 4) != 0;
      if (q_err === 1'b1)
         q_seen <= 1'b1;
      if (rstn && irq === 1'b1 && !quiet) begin
         if (exp_irq.size() == 0)
            chk(1, 0, "irq count");
         else
            chk({stat.err, stat.error[adh_pkg::ERR_ABRT], stat.error[adh_pkg::ERR_TK0NF]}, exp_irq.pop_front(), "status");
      end
      if (rstn && rd_valid === 1'b1 && rd_ready) begin
         if (exp_byte.size() == 0)
            chk(1, 0, "byte count");
         else
            chk(rd_data, exp_byte.pop_front(), "read byte");
      end
   end

   initial begin
      int t;
      logic [47:0] l;
      void'($urandom(32'h4bcb2d07));
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      chk(sec_word, 16'h0021, "security reset");
      sec_state <= 16'($urandom);
      repeat (3) @(posedge clk);
      chk(sec_word, sec_state & 16'h013F, "security word");
      exp_irq.push_back(3'b000);
      issue(adh_pkg::OP_IDLE_NOW, 0, 0, 0);
      settle();
      chk(pm_mode, adh_pkg::PM_IDLE, "idle mode");
      foreach (codes[k]) begin
         exp_irq.push_back(3'b000);
         issue(adh_pkg::OP_IDLE, 16'(codes[k]), 0, 0);
         @(posedge clk);
         for (t = 0; t < secs[k] * SC + 300 && pm_mode !== adh_pkg::PM_STANDBY; t++)
            @(posedge clk);
         chk(codes[k] == 0 ? t == 300 : t > secs[k] * SC - 8 && t < secs[k] * SC + 8, 1, "standby delay");
         spinning <= 1'b1;
         settle();
      end
      l = 48'($urandom);
      exp_irq.push_back(3'b000);
      issue(adh_pkg::OP_GEOM, 16'(l[7:0]), 0, l[12:8]);
      settle();
      chk({geom_spt, geom_heads}, {l[7:0], l[11:8]}, "geometry");
      exp_irq.push_back(3'b110);
      issue(adh_pkg::OP_NOP, 0, 0, 0);
      settle();
      quiet <= 1'b1;
      issue(adh_pkg::OP_WR_BUF, 0, 0, 0);
      repeat (4) @(posedge clk);
      quiet <= 1'b0;
      for (int i = 0; i < 512; i++) begin
         wr_data <= 8'($urandom);
         wr_valid <= 1'b1;
         @(posedge clk);
         exp_byte.push_back(wr_data);
      end
      wr_valid <= 1'b0;
      exp_irq.push_back(3'b000);
      issue(adh_pkg::OP_RD_BUF, 0, 0, 0);
      settle();
      l = 48'h1000 + 48'($urandom % 256);
      repeat (256) exp_irq.push_back(3'b000);
      expect_rd(l, 256);
      issue(adh_pkg::OP_RD_SEC, 0, l, 0);
      settle();
      chk(cmd_lba, l + 255, "last sector");
      // error stops dma before bad sector
      slow <= 1'b1;
      bad_en <= 1'b1;
      bad_lba <= l + 1;
      exp_irq.push_back(3'b100);
      expect_rd(l, 1);
      issue(adh_pkg::OP_RD_DMA, 3, l, 0);
      settle();
      chk(cmd_lba, l + 1, "failing sector");
      exp_irq.push_back(3'b100);
      issue(adh_pkg::OP_VFY_X, 4, l, 0);
      settle();
      chk({cmd_lba, cmd_count}, {l + 48'h1, 16'h3}, "verify result");
      media_corr <= 1'b1;
      mult_block <= 8'h03;
      exp_irq.push_back(3'b000);
      expect_rd(l, 1);
      repeat (adh_pkg::ECC_BYTES) exp_byte.push_back(8'h00);
      issue(adh_pkg::OP_RD_LONG, 1, l, 0);
      settle();
      repeat (2) exp_irq.push_back(3'b000);
      expect_rd(l, 5);
      issue(adh_pkg::OP_RD_MUL_X, 5, l, 0);
      settle();
      bad_en <= 1'b0;
      slow <= 1'b0;
      media_corr <= 1'b0;
      mult_enable <= 1'b0;
      exp_irq.push_back(3'b110);
      issue(adh_pkg::OP_RD_MUL, 5, l, 0);
      settle();
      seek_ok <= 1'b0;
      exp_irq.push_back(3'b101);
      issue(adh_pkg::OP_RECAL, 0, 0, 0);
      settle();
      seek_ok <= 1'b1;
      exp_irq.push_back(3'b000);
      issue(adh_pkg::OP_RECAL, 0, 0, 0);
      settle();
      for (int i = 0; i < 32; i++)
         issue(adh_pkg::OP_QREAD, 1, 48'(i), 5'(i));
      repeat (3) @(posedge clk);
      chk(q_busy, 32'hFFFFFFFF, "queue full");
      issue(adh_pkg::OP_QREAD, 1, 0, 5'h03);
      repeat (4) @(posedge clk);
      chk(q_seen, 1, "duplicate tag error");
      q_seen <= 1'b0;
      exp_irq.push_back(3'b110);
      issue(adh_pkg::OP_IDLE_NOW, 0, 0, 0);
      settle();
      chk(q_seen, 1, "non-queued error");
      for (int i = 31; i >= 0; i--) begin
         q_done <= 1'b1;
         q_done_tag <= 5'(i);
         @(posedge clk);
      end
      q_done <= 1'b0;
      repeat (3) @(posedge clk);
      chk(q_busy, 32'h0, "queue drained");
      wrap_up();
   end
endmodule : tb
